// File: tmc_top.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Mode field 000..100 selects five modes
// - Bit 3 picks one or both pin edges
// - Bits 6..4 pick undivided, /8, fast, /2
// - Bit 7 high blocks the count clock
// - Event mode counts pin, ignores source
// - Mode register write resets toggle flop
module tmc_top
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  // Count source inputs
  input  wire logic        fast_onchip_osc_clk_in,
  input  wire logic        timer_io_pin_in,
  // Timer side outputs
  output logic             count_tick_out,
  output logic [4:0]       op_mode_onehot_out,
  output logic             edge_polarity_sel_out,
  output logic             counting_status_flag_out,
  output logic             toggle_ff_out
);

  typedef struct packed {
    logic [7:0]  mode_cfg;
    logic        start_req;
    logic        status;
    logic        toggle;
    logic        tick;
    logic [4:0]  mode_onehot;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tmc_state_s;

  tmc_state_s state_r;
  tmc_state_s state_nxt;
  tmc_src_if  src_bus ();

  // Mode code to one-hot, illegal codes give none
  function automatic logic [4:0] tmc_mode_decode(input logic [2:0] code);
    logic [4:0] oh;
    oh = 5'h00;
    unique case (code)
      TMC_MODE_TIMER:  oh = 5'h01;
      TMC_MODE_PULSE:  oh = 5'h02;
      TMC_MODE_EVENT:  oh = 5'h04;
      TMC_MODE_PWIDTH: oh = 5'h08;
      TMC_MODE_PPER:   oh = 5'h10;
      default:         oh = 5'h00;
    endcase
    return oh;
  endfunction

  // Address check used in the setup phase
  function automatic logic tmc_addr_hit(input logic [7:0] addr);
    return (addr == TMC_MODE_CFG_ADDR) || (addr == TMC_CTRL_ADDR);
  endfunction

  logic setup_ph;
  logic access_wr;
  logic mode_wr;
  logic ctrl_wr;

  // APB phase decode
  always_comb begin
    setup_ph  = psel_in & ~penable_in;
    access_wr = psel_in & penable_in & state_r.pready & pwrite_in & ~state_r.pslverr;
    mode_wr   = access_wr & (paddr_in == TMC_MODE_CFG_ADDR);
    ctrl_wr   = access_wr & (paddr_in == TMC_CTRL_ADDR);
  end

  // Fields to the count source selector
  always_comb begin
    src_bus.op_mode            = state_r.mode_cfg[TMC_MODE_LSB +: 3];
    src_bus.count_src_sel      = state_r.mode_cfg[TMC_SRC_LSB +: 3];
    src_bus.edge_polarity_sel  = state_r.mode_cfg[TMC_EDGE_BIT];
    src_bus.count_src_gate_off = state_r.mode_cfg[TMC_GATE_BIT];
  end

  tmc_src_sel u_src (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .fast_onchip_osc_clk_in (fast_onchip_osc_clk_in),
    .timer_io_pin_in        (timer_io_pin_in),
    .cfg                    (src_bus)
  );

  // Next state: registers, status, toggle, APB answer
  always_comb begin
    state_nxt = state_r;
    // Answer is prepared in setup and shown in access
    state_nxt.pready  = setup_ph;
    state_nxt.pslverr = setup_ph & ~tmc_addr_hit(paddr_in);
    if (setup_ph) begin
      state_nxt.prdata = 32'h0000_0000;
      if (!pwrite_in && paddr_in == TMC_MODE_CFG_ADDR) begin
        state_nxt.prdata[7:0] = state_r.mode_cfg;
      end else if (!pwrite_in && paddr_in == TMC_CTRL_ADDR) begin
        state_nxt.prdata[TMC_START_BIT]  = state_r.start_req;
        state_nxt.prdata[TMC_STATUS_BIT] = state_r.status;
      end
    end
    // Register writes; mode and source are taken as written
    if (mode_wr) begin
      state_nxt.mode_cfg = pwdata_in[7:0];
    end
    if (ctrl_wr) begin
      state_nxt.start_req = pwdata_in[TMC_START_BIT];
    end
    // Status follows start request on a count clock tick
    if (src_bus.count_tick) begin
      state_nxt.status = state_r.start_req;
    end
    // Toggle in pulse output mode, reset by mode write
    if (mode_wr) begin
      state_nxt.toggle = 1'b0;
    end else if (src_bus.count_tick && state_r.status && state_r.mode_onehot[1]) begin
      state_nxt.toggle = ~state_r.toggle;
    end
    state_nxt.tick        = src_bus.count_tick;
    state_nxt.mode_onehot = tmc_mode_decode(state_r.mode_cfg[TMC_MODE_LSB +: 3]);
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r          <= '0;
      state_r.mode_cfg <= TMC_MODE_CFG_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flops
  assign pready_out               = state_r.pready;
  assign pslverr_out              = state_r.pslverr;
  assign prdata_out               = state_r.prdata;
  assign count_tick_out           = state_r.tick;
  assign op_mode_onehot_out       = state_r.mode_onehot;
  assign edge_polarity_sel_out    = state_r.mode_cfg[TMC_EDGE_BIT];
  assign counting_status_flag_out = state_r.status;
  assign toggle_ff_out            = state_r.toggle;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence mode_write_s;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == TMC_MODE_CFG_ADDR;
  endsequence

  sequence start_then_tick_s;
    state_r.start_req && src_bus.count_tick;
  endsequence

  // Steps of a register transfer
  sequence setup_s;
    psel_in && !penable_in;
  endsequence

  sequence mode_read_s;
    psel_in && !penable_in && !pwrite_in && paddr_in == TMC_MODE_CFG_ADDR;
  endsequence

  sequence ctrl_write_s;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == TMC_CTRL_ADDR;
  endsequence

  mode_decode_a: assert property (mode_write_s ##1 1'b1 |=> op_mode_onehot_out ==
      tmc_mode_decode($past(pwdata_in[2:0], 2)))
    else $error("operating mode decode wrong after write");
  toggle_reinit_a: assert property (mode_write_s |=> !toggle_ff_out)
    else $error("toggle flop not reset by mode write");
  status_follow_a: assert property (start_then_tick_s |=> counting_status_flag_out)
    else $error("status flag missed start on tick");
  status_hold_a: assert property (!src_bus.count_tick |=> $stable(counting_status_flag_out))
    else $error("status flag moved without count tick");
  gate_tick_out_a: assert property (src_bus.count_src_gate_off |=> !count_tick_out)
    else $error("count tick output while gated off");

  // Bus answer timing and refusal of unmapped addresses
  ready_after_setup_a: assert property (setup_s |=> pready_out)
    else $error("no ready in access cycle");
  ready_one_cycle_a: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  unmapped_err_a: assert property (psel_in && !penable_in && !tmc_addr_hit(paddr_in) |=> pslverr_out)
    else $error("unmapped address not refused");
  unmapped_ignored_a: assert property (psel_in && penable_in && pready_out && pslverr_out
      |=> $stable(state_r.mode_cfg) && $stable(state_r.start_req))
    else $error("refused write changed a register");

  // Register contents after writes and reads
  mode_store_a: assert property (mode_write_s |=> state_r.mode_cfg == $past(pwdata_in[7:0]))
    else $error("mode register did not take written value");
  mode_read_a: assert property (mode_read_s |=> prdata_out == {24'h0, $past(state_r.mode_cfg)})
    else $error("mode register read data wrong");
  ctrl_write_a: assert property (ctrl_write_s |=> state_r.start_req == $past(pwdata_in[TMC_START_BIT]))
    else $error("start request did not take written value");

  // Toggle moves only on a count tick or mode write, status only on a count tick
  toggle_still_a: assert property (!mode_wr && !(src_bus.count_tick && state_r.status)
      |=> $stable(toggle_ff_out))
    else $error("toggle flop moved without tick or mode write");
  gated_status_a: assert property (src_bus.count_src_gate_off |=> $stable(counting_status_flag_out))
    else $error("status flag moved while source gated off");
  status_clear_a: assert property (!state_r.start_req && src_bus.count_tick |=> !counting_status_flag_out)
    else $error("status flag stayed set after stop on tick");

endmodule

// File: tmc_pkg.sv
package tmc_pkg;
  // APB register byte addresses
  localparam logic [7:0] TMC_MODE_CFG_ADDR = 8'hdc;
  localparam logic [7:0] TMC_CTRL_ADDR     = 8'he0;
  // Mode configuration field positions
  localparam int TMC_MODE_LSB   = 0;
  localparam int TMC_EDGE_BIT   = 3;
  localparam int TMC_SRC_LSB    = 4;
  localparam int TMC_GATE_BIT   = 7;
  // Control register field positions
  localparam int TMC_START_BIT  = 0;
  localparam int TMC_STATUS_BIT = 1;
  // Reset values
  localparam logic [7:0] TMC_MODE_CFG_RST = 8'h00;
  localparam logic [7:0] TMC_DIV_RST      = 8'h00;
  // Divider terminal count and divide-by-2 mask
  localparam logic [2:0] TMC_DIV8_LAST = 3'h7;
  localparam logic [2:0] TMC_DIV2_MASK = 3'h1;
  // Operating mode codes
  localparam logic [2:0] TMC_MODE_TIMER  = 3'h0;
  localparam logic [2:0] TMC_MODE_PULSE  = 3'h1;
  localparam logic [2:0] TMC_MODE_EVENT  = 3'h2;
  localparam logic [2:0] TMC_MODE_PWIDTH = 3'h3;
  localparam logic [2:0] TMC_MODE_PPER   = 3'h4;
  // Count source codes
  localparam logic [2:0] TMC_SRC_DIV1 = 3'h0;
  localparam logic [2:0] TMC_SRC_DIV8 = 3'h1;
  localparam logic [2:0] TMC_SRC_FAST = 3'h2;
  localparam logic [2:0] TMC_SRC_DIV2 = 3'h3;
endpackage

// File: tmc_src_if.sv
`timescale 1ns/100ps
interface tmc_src_if;
  logic [2:0] op_mode;
  logic [2:0] count_src_sel;
  logic       edge_polarity_sel;
  logic       count_src_gate_off;
  logic       count_tick;
  modport ctrl (output op_mode, output count_src_sel, output edge_polarity_sel,
                output count_src_gate_off, input count_tick);
  modport src  (input op_mode, input count_src_sel, input edge_polarity_sel,
                input count_src_gate_off, output count_tick);
endinterface

// File: tmc_src_sel.sv
`timescale 1ns/100ps
module tmc_src_sel
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Count source inputs
  input  wire logic fast_onchip_osc_clk_in,
  input  wire logic timer_io_pin_in,
  // Configuration and tick
  tmc_src_if.src    cfg
);

  typedef struct packed {
    logic [2:0] div;
    logic       pin_prev;
  } tmc_src_s;

  tmc_src_s state_r;
  tmc_src_s state_nxt;
  logic     pin_edge;
  logic     src_tick;

  // Prescaler and pin history
  always_comb begin
    state_nxt          = state_r;
    state_nxt.div      = state_r.div + 3'h1;
    state_nxt.pin_prev = timer_io_pin_in;
  end

  // Pin edge: rising only, or both directions
  always_comb begin
    if (cfg.edge_polarity_sel) begin
      pin_edge = timer_io_pin_in ^ state_r.pin_prev;
    end else begin
      pin_edge = timer_io_pin_in & ~state_r.pin_prev;
    end
  end

  // Source select, event mode overrides, then gate
  always_comb begin
    src_tick = 1'b0;
    if (cfg.op_mode == TMC_MODE_EVENT) begin
      src_tick = pin_edge;
    end else begin
      unique case (cfg.count_src_sel)
        TMC_SRC_DIV1: src_tick = 1'b1;
        TMC_SRC_DIV8: src_tick = (state_r.div == TMC_DIV8_LAST);
        TMC_SRC_FAST: src_tick = fast_onchip_osc_clk_in;
        TMC_SRC_DIV2: src_tick = (state_r.div & TMC_DIV2_MASK) == TMC_DIV2_MASK;
        default:      src_tick = 1'b0;
      endcase
    end
    cfg.count_tick = src_tick & ~cfg.count_src_gate_off;
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  gate_blocks_tick_a: assert property (cfg.count_src_gate_off |-> !cfg.count_tick)
    else $error("count tick passed while source gated off");
  both_edges_tick_a: assert property ((cfg.op_mode == TMC_MODE_EVENT && cfg.edge_polarity_sel &&
      !cfg.count_src_gate_off && $fell(timer_io_pin_in)) |-> cfg.count_tick)
    else $error("falling edge not counted in two-way edge mode");
  one_edge_only_a: assert property ((cfg.op_mode == TMC_MODE_EVENT && !cfg.edge_polarity_sel &&
      $fell(timer_io_pin_in)) |-> !cfg.count_tick)
    else $error("falling edge counted in one-way edge mode");
  event_ignores_src_a: assert property ((cfg.op_mode == TMC_MODE_EVENT && $stable(timer_io_pin_in))
      |-> !cfg.count_tick)
    else $error("tick in event mode without pin edge");
  div8_period_a: assert property ((cfg.op_mode != TMC_MODE_EVENT && cfg.count_src_sel == TMC_SRC_DIV8 &&
      !cfg.count_src_gate_off && cfg.count_tick) |=>
      (!cfg.count_tick || cfg.count_src_sel != TMC_SRC_DIV8 || cfg.op_mode == TMC_MODE_EVENT) [*7])
    else $error("divide-by-8 tick spacing wrong");

endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top
  import tmc_pkg::*;
;
  logic        clk_in     = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [7:0]  paddr_in   = 8'h00;
  logic [31:0] pwdata_in  = 32'h0;
  logic        fast_in    = 1'b0;
  logic        pin_in     = 1'b0;
  logic [15:0] cyc        = 16'h0;
  logic        pready_out, pslverr_out, count_tick_out, edge_out, status_out, toggle_out;
  logic [31:0] prdata_out;
  logic [4:0]  onehot_out;
  int          n_errors    = 0;
  int          checks_done = 0;
  int          n_ticks     = 0;

  tmc_top tmc_top_i (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out), .fast_onchip_osc_clk_in(fast_in),
    .timer_io_pin_in(pin_in), .count_tick_out(count_tick_out), .op_mode_onehot_out(onehot_out),
    .edge_polarity_sel_out(edge_out), .counting_status_flag_out(status_out), .toggle_ff_out(toggle_out));

  // Clock, fast oscillator pulse every fourth cycle, tick counter
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 16'h1;
    fast_in <= (cyc[1:0] == 2'h3);
    if (count_tick_out === 1'b1) n_ticks <= n_ticks + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic t_reset_unmapped;
    rd_chk(TMC_MODE_CFG_ADDR, {24'h0, TMC_MODE_CFG_RST}, 1'b0);
    rd_chk(TMC_CTRL_ADDR, 32'h0, 1'b0);
    wr(8'h04, 32'hff);
    rd_chk(8'h04, 32'h0, 1'b1);
    rd_chk(TMC_MODE_CFG_ADDR, 32'h0, 1'b0);
  endtask

  // Every mode code, upper data bits set to show they read back as 0
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(TMC_MODE_CFG_ADDR, 32'hffffff00 | 32'(m));
      rd_chk(TMC_MODE_CFG_ADDR, 32'(m), 1'b0);
      chk({27'h0, onehot_out}, (m < 5) ? (32'h1 << m) : 32'h0);
    end
  endtask

  // Each source, supplied then cut off, ticks counted over 16 cycles
  task automatic t_sources;
    int exp [4] = '{16, 2, 4, 8};
    int t0;
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < 4; s++) begin
        wr(TMC_MODE_CFG_ADDR, {24'h0, g[0], s[2:0], 1'b0, TMC_MODE_TIMER});
        repeat (4) @(posedge clk_in);
        t0 = n_ticks;
        repeat (16) @(posedge clk_in);
        chk(32'(n_ticks - t0), (g == 0) ? 32'(exp[s]) : 32'h0);
      end
    end
  endtask

  // Event mode counts pin edges, one way then both ways
  task automatic t_event;
    int t0;
    for (int e = 0; e < 2; e++) begin
      wr(TMC_MODE_CFG_ADDR, {24'h0, 1'b0, TMC_SRC_DIV1, e[0], TMC_MODE_EVENT});
      chk({31'h0, edge_out}, 32'(e));
      repeat (4) @(posedge clk_in);
      t0 = n_ticks;
      repeat (8) begin
        pin_in <= ~pin_in;
        repeat (2) @(posedge clk_in);
      end
      repeat (3) @(posedge clk_in);
      chk(32'(n_ticks - t0), (e == 1) ? 32'h8 : 32'h4);
    end
  endtask

  // Start, toggle in pulse mode, stop, then a mode write clears toggle
  task automatic t_toggle;
    logic [31:0] cfg;
    cfg = {24'h0, 1'b0, TMC_SRC_DIV8, 1'b0, TMC_MODE_PULSE};
    wr(TMC_MODE_CFG_ADDR, cfg);
    wr(TMC_CTRL_ADDR, 32'h1);
    for (int n = 0; n < 40 && status_out !== 1'b1; n++) @(posedge clk_in);
    rd_chk(TMC_CTRL_ADDR, 32'h3, 1'b0);
    for (int n = 0; n < 40 && toggle_out !== 1'b1; n++) @(posedge clk_in);
    chk({31'h0, toggle_out}, 32'h1);
    // Stop just after a fall, so the last tick leaves toggle high
    for (int n = 0; n < 40 && toggle_out !== 1'b0; n++) @(posedge clk_in);
    wr(TMC_CTRL_ADDR, 32'h0);
    for (int n = 0; n < 40 && status_out !== 1'b0; n++) @(posedge clk_in);
    rd_chk(TMC_CTRL_ADDR, 32'h0, 1'b0);
    chk({31'h0, toggle_out}, 32'h1);
    wr(TMC_MODE_CFG_ADDR, cfg);
    chk({31'h0, toggle_out}, 32'h0);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_reset_unmapped();
    t_modes();
    t_sources();
    t_event();
    t_toggle();
    end_sim();
  end
endmodule
